//--- rtl/otpprg_pkg.sv
package otpprg_pkg;
	// ****************************************************************
	// clock and geometry
	// ****************************************************************
	localparam int          CLK_PERIOD_PS   = 50000;
	localparam int          ADDR_W          = 18;
	localparam int          DATA_W          = 16;
	localparam logic [17:0] ADDR_FIRST      = 18'h00000;
	localparam logic [17:0] ADDR_LAST       = 18'h3ffff;

	// ****************************************************************
	// timing, figures as printed, cycles derived
	// ****************************************************************
	localparam int PW_MIN_NS         = 47500;
	localparam int PW_MAX_NS         = 52500;
	localparam int PW_NOM_NS         = 50000;
	localparam int SETUP_US          = 2;
	localparam int OE_VALID_NS       = 150;
	localparam int OE_FLOAT_NS       = 130;
	localparam int PW_MIN_CYC        = (PW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PW_MAX_CYC        = (PW_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int PW_CYC            = (PW_NOM_NS * 1000) / CLK_PERIOD_PS;
	localparam int SETUP_CYC         = (SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OE_VALID_CYC      = (OE_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OE_FLOAT_CYC      = (OE_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W             = 12;
	localparam logic [3:0] MAX_RETRY = 4'ha;

	// ****************************************************************
	// supply levels driven out
	// ****************************************************************
	typedef enum logic [1:0] {
		OTPPRG_SUP_OFF  = 2'b00,
		OTPPRG_SUP_READ = 2'b01,
		OTPPRG_SUP_PROG = 2'b10,
		OTPPRG_SUP_ID   = 2'b11
	} otpprg_sup_t;

	// ****************************************************************
	// sequencer states
	// ****************************************************************
	typedef enum logic [4:0] {
		OTPPRG_IDLE      = 5'b00000,
		OTPPRG_VCC_UP    = 5'b00001,
		OTPPRG_VPP_UP    = 5'b00010,
		OTPPRG_P1_SETUP  = 5'b00011,
		OTPPRG_P1_PULSE  = 5'b00100,
		OTPPRG_P1_HOLD   = 5'b00101,
		OTPPRG_V_SETUP   = 5'b00110,
		OTPPRG_V_OE      = 5'b00111,
		OTPPRG_V_FLOAT   = 5'b01000,
		OTPPRG_R_PULSE   = 5'b01001,
		OTPPRG_R_HOLD    = 5'b01010,
		OTPPRG_VPP_DN    = 5'b01011,
		OTPPRG_VCC_DN    = 5'b01100,
		OTPPRG_F_SETUP   = 5'b01101,
		OTPPRG_F_OE      = 5'b01110,
		OTPPRG_F_FLOAT   = 5'b01111,
		OTPPRG_ID_SETUP  = 5'b10000,
		OTPPRG_ID_OE     = 5'b10001,
		OTPPRG_ID_FLOAT  = 5'b10010,
		OTPPRG_OFF       = 5'b10011,
		OTPPRG_DONE      = 5'b10100
	} otpprg_state_t;

	// checks whether a word in progress is the last one
	function automatic logic otpprg_is_last(input logic [17:0] a);
		return a == ADDR_LAST;
	endfunction
endpackage

//--- rtl/otpprg_timer.sv
`timescale 1ns/10ps
// down counter; done pulses once the loaded count has run out
module otpprg_timer
	import otpprg_pkg::*;
(
	input  wire logic             mclk_in,
	input  wire logic             nrst_in,
	input  wire logic             load_in,
	input  wire logic [TMR_W-1:0] count_in,
	output logic                  done_out
);
	logic [TMR_W-1:0] cnt_ff;
	logic             run_ff;

	// ****************************************************************
	// counter
	// ****************************************************************
	// load wins over a running count so a state can restart it
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end else if (load_in) begin
			cnt_ff <= count_in;
			run_ff <= 1'b1;
		end else if (run_ff && cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
		end else begin
			run_ff <= 1'b0;
		end
	end

	// done must not look at load: the sequencer derives load from done
	assign done_out = run_ff && cnt_ff == '0;
endmodule

//--- rtl/otpprg_ctrl.sv
`timescale 1ns/10ps
module otpprg_ctrl
	import otpprg_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              nrst_in,
	input  wire logic              start_prog_in,
	input  wire logic              start_id_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic [DATA_W-1:0] dev_data_in,
	output logic [ADDR_W-1:0]      dev_addr_out,
	output logic [DATA_W-1:0]      dev_data_out,
	output logic                   dev_data_oe_out,
	output logic                   chip_en_n_out,
	output logic                   out_en_n_out,
	output logic                   vcc_prog_out,
	output logic                   vpp_prog_out,
	output logic                   vcc_on_out,
	output logic                   vpp_on_out,
	output logic                   id_mode_voltage_out,
	output logic [ADDR_W-1:0]      data_req_addr_out,
	output logic                   busy_out,
	output logic                   done_out,
	output logic                   pass_out,
	output logic                   fail_out,
	output logic [DATA_W-1:0]      id_maker_out,
	output logic [DATA_W-1:0]      id_type_out
);
	otpprg_state_t    state_ff;
	otpprg_state_t    nxt_state;
	logic [17:0]      addr_ff;
	logic [15:0]      dout_ff;
	logic             doe_ff;
	logic             ce_n_ff;
	logic             oe_n_ff;
	logic             vcc_prog_ff;
	logic             vpp_prog_ff;
	logic             vcc_on_ff;
	logic             vpp_on_ff;
	logic             idv_ff;
	logic [3:0]       retry_ff;
	logic             id_sel_ff;
	logic             done_ff;
	logic             pass_ff;
	logic             fail_ff;
	logic [15:0]      maker_ff;
	logic [15:0]      type_ff;
	logic             busy_ff;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic             tmr_done;
	logic             match;
	logic             vmatch_ff;

	// ****************************************************************
	// wait timer
	// ****************************************************************
	otpprg_timer u_timer (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.load_in  (tmr_load),
		.count_in (tmr_count),
		.done_out (tmr_done)
	);

	// data at the address must be held by the user while addr shown
	assign match = dev_data_in == wr_data_in;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		tmr_load  = 1'b0;
		tmr_count = TMR_W'(SETUP_CYC);
		case (state_ff)
			OTPPRG_IDLE: begin
				if (start_prog_in) begin
					nxt_state = OTPPRG_VCC_UP;
					tmr_load  = 1'b1;
				end else if (start_id_in) begin
					nxt_state = OTPPRG_ID_SETUP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_VCC_UP: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_VPP_UP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_VPP_UP: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_P1_SETUP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_P1_SETUP: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_P1_PULSE;
					tmr_load  = 1'b1;
					tmr_count = TMR_W'(PW_CYC);
				end
			end
			OTPPRG_P1_PULSE: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_P1_HOLD;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_P1_HOLD: begin
				if (tmr_done) begin
					// no verify in first pass
					nxt_state = otpprg_is_last(addr_ff) ? OTPPRG_V_SETUP : OTPPRG_P1_SETUP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_V_SETUP, OTPPRG_F_SETUP, OTPPRG_ID_SETUP: begin
				if (tmr_done) begin
					nxt_state = (state_ff == OTPPRG_V_SETUP) ? OTPPRG_V_OE :
					            (state_ff == OTPPRG_F_SETUP) ? OTPPRG_F_OE : OTPPRG_ID_OE;
					tmr_load  = 1'b1;
					tmr_count = TMR_W'(OE_VALID_CYC);
				end
			end
			OTPPRG_V_OE, OTPPRG_F_OE, OTPPRG_ID_OE: begin
				if (tmr_done) begin
					nxt_state = (state_ff == OTPPRG_V_OE) ? OTPPRG_V_FLOAT :
					            (state_ff == OTPPRG_F_OE) ? OTPPRG_F_FLOAT : OTPPRG_ID_FLOAT;
					tmr_load  = 1'b1;
					tmr_count = TMR_W'(OE_FLOAT_CYC);
				end
			end
			OTPPRG_V_FLOAT: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					if (!vmatch_ff && retry_ff == MAX_RETRY) begin
						nxt_state = OTPPRG_VPP_DN;
					end else if (!vmatch_ff) begin
						nxt_state = OTPPRG_R_PULSE;
						tmr_count = TMR_W'(PW_CYC);
					end else if (otpprg_is_last(addr_ff)) begin
						nxt_state = OTPPRG_VPP_DN;
					end else begin
						nxt_state = OTPPRG_V_SETUP;
					end
				end
			end
			OTPPRG_R_PULSE: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_R_HOLD;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_R_HOLD: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_V_SETUP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_VPP_DN: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_VCC_DN;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_VCC_DN: begin
				if (tmr_done) begin
					nxt_state = fail_ff ? OTPPRG_OFF : OTPPRG_F_SETUP;
					tmr_load  = 1'b1;
				end
			end
			OTPPRG_F_FLOAT: begin
				if (tmr_done) begin
					tmr_load  = 1'b1;
					nxt_state = otpprg_is_last(addr_ff) ? OTPPRG_OFF : OTPPRG_F_SETUP;
				end
			end
			OTPPRG_ID_FLOAT: begin
				if (tmr_done) begin
					tmr_load  = 1'b1;
					nxt_state = id_sel_ff ? OTPPRG_OFF : OTPPRG_ID_SETUP;
				end
			end
			OTPPRG_OFF: begin
				if (tmr_done) begin
					nxt_state = OTPPRG_DONE;
				end
			end
			OTPPRG_DONE: begin
				nxt_state = OTPPRG_IDLE;
			end
			default: begin
				nxt_state = OTPPRG_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= OTPPRG_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// address and retry count
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_ff  <= ADDR_FIRST;
			retry_ff <= 4'h0;
		end else if (state_ff == OTPPRG_IDLE) begin
			addr_ff  <= ADDR_FIRST;
			retry_ff <= 4'h0;
		end else if (tmr_done) begin
			case (state_ff)
				OTPPRG_P1_HOLD: begin
					addr_ff <= otpprg_is_last(addr_ff) ? ADDR_FIRST : addr_ff + 1'b1;
				end
				OTPPRG_V_FLOAT: begin
					if (vmatch_ff) begin
						addr_ff  <= otpprg_is_last(addr_ff) ? ADDR_FIRST : addr_ff + 1'b1;
						retry_ff <= 4'h0;
					end
				end
				OTPPRG_R_PULSE: begin
					retry_ff <= retry_ff + 1'b1;
				end
				OTPPRG_F_FLOAT: begin
					addr_ff <= addr_ff + 1'b1;
				end
				default: begin
					addr_ff <= addr_ff;
				end
			endcase
		end
	end

	// ****************************************************************
	// verify result
	// ****************************************************************
	// the bus floats once oe rises, so the word is judged inside the window
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			vmatch_ff <= 1'b0;
		end else if (state_ff == OTPPRG_V_OE && tmr_done) begin
			vmatch_ff <= match;
		end
	end

	// ****************************************************************
	// pin drive
	// ****************************************************************
	// ce low during pulse states and the oe read states, so pulse width is fixed by timer
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			doe_ff  <= 1'b0;
			dout_ff <= 16'h0000;
		end else begin
			ce_n_ff <= !(nxt_state == OTPPRG_P1_PULSE || nxt_state == OTPPRG_R_PULSE ||
			             nxt_state == OTPPRG_V_OE || nxt_state == OTPPRG_F_OE ||
			             nxt_state == OTPPRG_ID_OE);
			oe_n_ff <= !(nxt_state == OTPPRG_V_OE || nxt_state == OTPPRG_F_OE ||
			             nxt_state == OTPPRG_ID_OE);
			// bus released through oe and float windows
			doe_ff  <= nxt_state == OTPPRG_P1_SETUP || nxt_state == OTPPRG_P1_PULSE ||
			           nxt_state == OTPPRG_P1_HOLD || nxt_state == OTPPRG_R_PULSE ||
			           nxt_state == OTPPRG_R_HOLD;
			dout_ff <= wr_data_in;
		end
	end

	// ****************************************************************
	// supplies
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			vcc_on_ff   <= 1'b0;
			vpp_on_ff   <= 1'b0;
			vcc_prog_ff <= 1'b0;
			vpp_prog_ff <= 1'b0;
			idv_ff      <= 1'b0;
		end else begin
			vcc_on_ff   <= nxt_state != OTPPRG_IDLE && nxt_state != OTPPRG_DONE;
			vpp_on_ff   <= nxt_state != OTPPRG_IDLE && nxt_state != OTPPRG_DONE &&
			               nxt_state != OTPPRG_VCC_UP && nxt_state != OTPPRG_OFF;
			vcc_prog_ff <= (nxt_state >= OTPPRG_VCC_UP && nxt_state <= OTPPRG_VPP_DN);
			vpp_prog_ff <= (nxt_state >= OTPPRG_VPP_UP && nxt_state <= OTPPRG_R_HOLD);
			idv_ff      <= nxt_state == OTPPRG_ID_SETUP || nxt_state == OTPPRG_ID_OE ||
			               nxt_state == OTPPRG_ID_FLOAT;
		end
	end

	// ****************************************************************
	// id select, results
	// ****************************************************************
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			id_sel_ff <= 1'b0;
			maker_ff  <= 16'h0000;
			type_ff   <= 16'h0000;
			done_ff   <= 1'b0;
			pass_ff   <= 1'b0;
			fail_ff   <= 1'b0;
			busy_ff   <= 1'b0;
		end else begin
			busy_ff <= nxt_state != OTPPRG_IDLE;
			done_ff <= nxt_state == OTPPRG_DONE;
			if (state_ff == OTPPRG_IDLE && (start_prog_in || start_id_in)) begin
				id_sel_ff <= 1'b0;
				pass_ff   <= 1'b0;
				fail_ff   <= 1'b0;
			end
			if (state_ff == OTPPRG_ID_OE && tmr_done) begin
				if (id_sel_ff) type_ff <= dev_data_in;
				else maker_ff <= dev_data_in;
			end
			if (state_ff == OTPPRG_ID_FLOAT && tmr_done) begin
				id_sel_ff <= 1'b1;
			end
			if (state_ff == OTPPRG_V_FLOAT && tmr_done && !vmatch_ff && retry_ff == MAX_RETRY) begin
				fail_ff <= 1'b1;
			end
			if (state_ff == OTPPRG_F_OE && tmr_done && !match) begin
				fail_ff <= 1'b1;
			end
			// only a clean final reread up to the last word counts as a pass
			if (state_ff == OTPPRG_F_FLOAT && tmr_done && otpprg_is_last(addr_ff)) begin
				pass_ff <= !fail_ff;
			end
		end
	end

	// id reads hold every other line low
	assign dev_addr_out        = idv_ff ? {17'h00000, id_sel_ff} : addr_ff;
	assign dev_data_out        = dout_ff;
	assign dev_data_oe_out     = doe_ff;
	assign chip_en_n_out       = ce_n_ff;
	assign out_en_n_out        = oe_n_ff;
	assign vcc_prog_out        = vcc_prog_ff;
	assign vpp_prog_out        = vpp_prog_ff;
	assign vcc_on_out          = vcc_on_ff;
	assign vpp_on_out          = vpp_on_ff;
	assign id_mode_voltage_out = idv_ff;
	assign data_req_addr_out   = addr_ff;
	assign busy_out            = busy_ff;
	assign done_out            = done_ff;
	assign pass_out            = pass_ff;
	assign fail_out            = fail_ff;
	assign id_maker_out        = maker_ff;
	assign id_type_out         = type_ff;
endmodule

//--- tb/otpprg_checker.sv
`timescale 1ns/10ps
// ****
// port checker for the program sequencer
// ****
module otpprg_checker
	import otpprg_pkg::*;
(
	input wire logic              mclk_in,
	input wire logic              nrst_in,
	input wire logic [ADDR_W-1:0] dev_addr_out,
	input wire logic              dev_data_oe_out,
	input wire logic              chip_en_n_out,
	input wire logic              out_en_n_out,
	input wire logic              vcc_prog_out,
	input wire logic              vpp_prog_out,
	input wire logic              vcc_on_out,
	input wire logic              vpp_on_out,
	input wire logic              id_mode_voltage_out,
	input wire logic              done_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	logic [10:0]       low_cnt_ff;
	logic [3:0]        pulses_ff;
	logic [ADDR_W-1:0] paddr_ff;

	// program pulse length; reads drop ce and oe together so they stay at zero
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_cnt_ff <= 11'h000;
		end else if (chip_en_n_out) begin
			low_cnt_ff <= 11'h000;
		end else if (out_en_n_out) begin
			low_cnt_ff <= low_cnt_ff + 11'h001;
		end
	end

	// pulses in a row on one address
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pulses_ff <= 4'h0;
			paddr_ff  <= '0;
		end else if ($fell(chip_en_n_out) && out_en_n_out) begin
			pulses_ff <= (dev_addr_out == paddr_ff) ? pulses_ff + 4'h1 : 4'h1;
			paddr_ff  <= dev_addr_out;
		end
	end

	a_pulse_width: assert property ($rose(chip_en_n_out) && $past(out_en_n_out) |->
		low_cnt_ff >= PW_MIN_CYC && low_cnt_ff <= PW_MAX_CYC) else $error("program pulse length off");
	a_pulse_supply: assert property (!chip_en_n_out && out_en_n_out |->
		vpp_prog_out && vcc_prog_out && dev_data_oe_out) else $error("pulse without supplies or data");
	a_retry_limit: assert property (pulses_ff <= 4'ha) else $error("too many pulses on one word");
	a_supply_order: assert property (vpp_on_out |-> vcc_on_out) else $error("vpp on without vcc");
	a_level_order: assert property ($fell(vcc_prog_out) |-> !vpp_prog_out) else $error("vcc lowered first");
	a_oe_valid_wait: assert property ($fell(out_en_n_out) |-> !out_en_n_out [*3])
		else $error("output enable window too short");
	a_float_gap: assert property ($rose(out_en_n_out) |-> !dev_data_oe_out [*3])
		else $error("data driven before float time");
	a_no_bus_fight: assert property (!out_en_n_out |-> !dev_data_oe_out) else $error("data driven during read");
	a_id_address: assert property (id_mode_voltage_out |-> dev_addr_out[ADDR_W-1:1] == '0)
		else $error("id read with other address bits high");
	a_done_single: assert property (done_out |=> !done_out) else $error("done longer than one cycle");

	c_pulse: cover property ($rose(chip_en_n_out) && $past(out_en_n_out));
	c_id_read: cover property (id_mode_voltage_out && !out_en_n_out);
	c_done: cover property (done_out);
endmodule

bind otpprg_ctrl otpprg_checker u_chk (.mclk_in, .nrst_in, .dev_addr_out, .dev_data_oe_out, .chip_en_n_out,
	.out_en_n_out, .vcc_prog_out, .vpp_prog_out, .vcc_on_out, .vpp_on_out, .id_mode_voltage_out, .done_out);

//--- tb/otpprg_dev_model.sv
`timescale 1ns/10ps
// ****
// behavioural memory device, sixteen words deep
// ****
module otpprg_dev_model
	import otpprg_pkg::*;
#(
	parameter logic [DATA_W-1:0] MAKER_CODE = 16'h5a01, // arbitrary value
	parameter logic [DATA_W-1:0] TYPE_CODE  = 16'h5a02  // arbitrary value
)(
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic              data_oe_in,
	input  wire logic              ce_n_in,
	input  wire logic              oe_n_in,
	input  wire logic              vpp_prog_in,
	input  wire logic              id_volt_in,
	output logic      [DATA_W-1:0] data_out
);
	logic [DATA_W-1:0] mem [0:15];
	logic [DATA_W-1:0] last;

	// blank cells read all ones
	initial begin
		last     = 16'h0000;
		data_out = 16'hffff;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'hffff;
		end
	end

	// a pulse only clears bits, so a repeat pulse is harmless
	always @(posedge ce_n_in) begin
		if (oe_n_in && vpp_prog_in && data_oe_in) begin
			mem[addr_in[3:0]] = mem[addr_in[3:0]] & data_in;
		end
	end

	// outside a read the pins show the inverse of the last word, so a late sample cannot pass
	always @(ce_n_in, oe_n_in, addr_in, id_volt_in) begin
		data_out = ~last;
		if (!ce_n_in && !oe_n_in) begin
			#100;
			last     = id_volt_in ? (addr_in[0] ? TYPE_CODE : MAKER_CODE) : mem[addr_in[3:0]];
			data_out = last;
		end
	end
endmodule

//--- tb/otp_word_program_sequence_tb.sv
`timescale 1ns/10ps
// ****
// sequencer bench: id read, refused start, head of a program run, reset mid-run
// ****
module otp_word_program_sequence_tb
	import otpprg_pkg::*;
;
	localparam logic [DATA_W-1:0] MAKER = 16'h5a01; // arbitrary value
	localparam logic [DATA_W-1:0] DTYPE = 16'h5a02; // arbitrary value

	logic              mclk_in, nrst_in, start_prog_in, start_id_in;
	logic [DATA_W-1:0] wr_data_in, dev_data_in, dev_data_out, id_maker_out, id_type_out;
	logic [ADDR_W-1:0] dev_addr_out, data_req_addr_out;
	logic              dev_data_oe_out, chip_en_n_out, out_en_n_out, vcc_prog_out, vpp_prog_out;
	logic              vcc_on_out, vpp_on_out, id_mode_voltage_out, busy_out, done_out, pass_out, fail_out;
	int                errors, check_count;

	otpprg_ctrl dut (.mclk_in, .nrst_in, .start_prog_in, .start_id_in, .wr_data_in, .dev_data_in, .dev_addr_out,
		.dev_data_out, .dev_data_oe_out, .chip_en_n_out, .out_en_n_out, .vcc_prog_out, .vpp_prog_out, .vcc_on_out,
		.vpp_on_out, .id_mode_voltage_out, .data_req_addr_out, .busy_out, .done_out, .pass_out, .fail_out,
		.id_maker_out, .id_type_out);

	otpprg_dev_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DTYPE)) u_dev (.addr_in(dev_addr_out),
		.data_in(dev_data_out), .data_oe_in(dev_data_oe_out), .ce_n_in(chip_en_n_out), .oe_n_in(out_en_n_out),
		.vpp_prog_in(vpp_prog_out), .id_volt_in(id_mode_voltage_out), .data_out(dev_data_in));

	function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
		return {a[7:0], ~a[7:0]};
	endfunction

	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	// word to program follows the requested index one cycle late
	always @(posedge mclk_in) begin
		wr_data_in <= pat(data_req_addr_out);
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_range(input int n, input int lo, input int hi);
		check_count++;
		if (n < lo || n > hi) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h..%h", $time, n, lo, hi);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// id read; a program start while busy must be ignored
	task automatic test_id();
		int   n;
		logic hv;
		hv = 1'b0;
		@(posedge mclk_in);
		start_id_in <= 1'b1;
		@(posedge mclk_in);
		start_id_in   <= 1'b0;
		start_prog_in <= 1'b1;
		@(posedge mclk_in);
		start_prog_in <= 1'b0;
		for (n = 0; n < 1000 && done_out !== 1'b1; n++) begin
			@(posedge mclk_in);
			#1;
			hv = hv | (vpp_prog_out === 1'b1);
		end
		chk_word(done_out, 1'b1);
		chk_word(hv, 1'b0);
		chk_word({busy_out, pass_out, fail_out}, 3'h4);
		chk_word(id_maker_out, MAKER);
		chk_word(id_type_out, DTYPE);
		$display("test_id finished at %0t", $time);
	endtask

	// first pass: one pulse per word from the first address, no verify, then reset mid-run
	task automatic test_prog();
		int   n;
		logic oe_seen;
		oe_seen = 1'b0;
		@(posedge mclk_in);
		start_prog_in <= 1'b1;
		@(posedge mclk_in);
		start_prog_in <= 1'b0;
		for (n = 0; n < 100 && vcc_on_out !== 1'b1; n++) begin
			@(posedge mclk_in);
			#1;
		end
		chk_word(vpp_on_out, 1'b0);
		for (int w = 0; w < 4; w++) begin
			for (n = 0; n < 3000 && chip_en_n_out !== 1'b0; n++) begin
				@(posedge mclk_in);
				#1;
			end
			chk_word(dev_addr_out, w);
			chk_word(data_req_addr_out, w);
			chk_word(dev_data_out, pat(w));
			chk_word({vcc_on_out, vcc_prog_out, vpp_on_out, vpp_prog_out}, 4'hf);
			for (n = 0; n < 2000 && chip_en_n_out === 1'b0; n++) begin
				oe_seen = oe_seen | (out_en_n_out !== 1'b1);
				@(posedge mclk_in);
				#1;
			end
			chk_range(n, PW_MIN_CYC, PW_MAX_CYC);
		end
		chk_word(oe_seen, 1'b0);
		for (int w = 0; w < 4; w++) begin
			chk_word(u_dev.mem[w], pat(w));
		end
		@(posedge mclk_in);
		nrst_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		chk_word({chip_en_n_out, out_en_n_out, vcc_on_out, vpp_on_out, busy_out}, 5'h18);
		@(posedge mclk_in);
		nrst_in <= 1'b1;
		$display("test_prog finished at %0t", $time);
	endtask

	// hang guard, well above the expected run of about 4700 cycles
	initial begin
		repeat (20000) @(posedge mclk_in);
		errors++;
		end_sim();
	end

	initial begin
		errors        = 0;
		check_count   = 0;
		nrst_in       = 1'b0;
		start_prog_in = 1'b0;
		start_id_in   = 1'b0;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		test_id();
		test_prog();
		test_id();
		end_sim();
	end
endmodule
